// [pkg/acs_pkg.sv]
// Constants, field layouts and state types for the converter control block.
// Assumes a single 200 MHz system clock; all other rates are derived enables.
package acs_pkg;
  // System clock and internal conversion oscillator
  localparam int MCLK_HZ = 200_000_000;
  localparam int INT_OSC_HZ = 307_200;
  localparam int INT_OSC_DIV = (MCLK_HZ + INT_OSC_HZ / 2) / INT_OSC_HZ;
  localparam int DIV_W = 12;
  // Conversion length in conversion clock ticks
  localparam int CONV_TICKS_1X = 41036;
  localparam int CONV_TICKS_2X = 20556;
  localparam int CONV_W = 16;
  // No conversion clock edge for this many system cycles means internal oscillator
  localparam int EXT_CLK_TIMEOUT = 2048;
  localparam int IDLE_W = 12;
  // Internal serial clock runs at conversion clock / 8: four ticks per half period
  localparam int ISCK_HALF_TICKS = 4;
  localparam int ISCK_W = 3;
  // Power-up wait before the serial clock pin level is trusted
  localparam int STRAP_WAIT = 3;
  // Output word layout
  localparam int WORD_BITS = 24;
  localparam int RESULT_BITS = 17;
  localparam int TAIL_BITS = 4;
  localparam int SAMPLE_BITS = 18;
  localparam int BITCNT_W = 5;
  localparam logic [RESULT_BITS-1:0] MAG_MAX = 17'h1ffff;
  localparam logic [RESULT_BITS-1:0] MAG_MIN = 17'h00000;
  localparam logic [RESULT_BITS-1:0] MAG_TOP = 17'h1fffe;
  localparam logic [RESULT_BITS-1:0] MAG_BOT = 17'h00001;
  localparam logic [TAIL_BITS-1:0] TAIL_ZERO = 4'h0;
  // Configuration word shifted in during the data phase
  localparam int CFG_BITS = 16;
  localparam int CFG_SPEED_POS = 7;
  localparam logic [CFG_BITS-1:0] CFG_RESET = 16'h0000;
  // Result buffer
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [2:0] {
    ST_CONVERT = 3'b000,
    ST_STORE = 3'b001,
    ST_LOAD = 3'b010,
    ST_SLEEP = 3'b011,
    ST_DATA = 3'b100
  } acs_state_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_OFFSET_CAL = 2'b01,
    PH_GAIN_CAL = 2'b10,
    PH_SAMPLE = 2'b11
  } acs_phase_t;
endpackage : acs_pkg

// [design/acs_control.sv]
// Converter control: conversion/sleep/data sequencing, serial link, result buffer.
// Assumes cs_n, sck_in, serial_in and conv_clock_select are asynchronous pins;
// sample_code, sample_over and sample_under come from logic on mclk.
module acs_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : acs_fifo

module acs_control
  import acs_pkg::*;
#(
  parameter int CONV_TICKS_1X_P = acs_pkg::CONV_TICKS_1X,
  parameter int CONV_TICKS_2X_P = acs_pkg::CONV_TICKS_2X,
  parameter int EXT_CLK_TIMEOUT_P = acs_pkg::EXT_CLK_TIMEOUT,
  parameter int INT_OSC_DIV_P = acs_pkg::INT_OSC_DIV
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic conv_clock_select,
  input wire logic [acs_pkg::SAMPLE_BITS-1:0] sample_code,
  input wire logic sample_over,
  input wire logic sample_under,
  output logic [acs_pkg::CFG_BITS-1:0] cfg_word,
  output logic [1:0] cal_phase,
  output logic conv_busy,
  output logic low_power,
  output logic ext_sck_mode,
  output logic ext_conv_clock
);
  import acs_pkg::*;

  function automatic logic [WORD_BITS-1:0] build_word(
    input logic [SAMPLE_BITS-1:0] code,
    input logic over,
    input logic under
  );
    logic sign;
    logic [RESULT_BITS-1:0] mag;
    sign = ~code[SAMPLE_BITS-1];
    mag = code[RESULT_BITS-1:0];
    // Extremes are reserved so range faults stay distinguishable
    if (over) begin
      sign = 1'b1;
      mag = MAG_MAX;
    end else if (under) begin
      sign = 1'b0;
      mag = MAG_MIN;
    end else if (sign && mag > MAG_TOP) begin
      mag = MAG_TOP;
    end else if (!sign && mag < MAG_BOT) begin
      mag = MAG_BOT;
    end
    build_word = {1'b0, 1'b0, sign, mag, TAIL_ZERO};
  endfunction : build_word

  acs_state_t state;
  logic [1:0] cs_s;
  logic [1:0] sck_s;
  logic [1:0] sdi_s;
  logic [1:0] f0_s;
  logic cs_d;
  logic sck_d;
  logic f0_d;
  logic cs_fall;
  logic cs_rise;
  logic f0_rise;
  logic [DIV_W-1:0] osc_cnt;
  logic int_tick;
  logic [IDLE_W-1:0] idle_cnt;
  logic conv_tick;
  logic [1:0] strap_cnt;
  logic [ISCK_W-1:0] isck_cnt;
  logic isck_run;
  logic isck_toggle;
  logic rise_ev;
  logic fall_ev;
  logic [CONV_W-1:0] conv_cnt;
  logic [CONV_W-1:0] conv_len;
  logic [BITCNT_W-1:0] rise_cnt;
  logic [WORD_BITS-1:0] shreg;
  logic [CFG_BITS-1:0] cfg_shift;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_BITS-1:0] fifo_out_data;
  logic push;
  logic pop;
  logic [WORD_BITS-1:0] next_word;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_s <= 2'h3;
      sck_s <= 2'h0;
      sdi_s <= 2'h0;
      f0_s <= 2'h0;
      cs_d <= 1'b1;
      sck_d <= 1'b0;
      f0_d <= 1'b0;
    end else begin
      cs_s <= {cs_s[0], cs_n};
      sck_s <= {sck_s[0], sck_in};
      sdi_s <= {sdi_s[0], serial_in};
      f0_s <= {f0_s[0], conv_clock_select};
      cs_d <= cs_s[1];
      sck_d <= sck_s[1];
      f0_d <= f0_s[1];
    end
  end
  assign cs_fall = cs_d & ~cs_s[1];
  assign cs_rise = ~cs_d & cs_s[1];
  assign f0_rise = f0_s[1] & ~f0_d;

  // Internal oscillator divider
  always_ff @(posedge mclk) begin
    if (rst || int_tick) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_cnt + 1'b1;
    end
  end
  assign int_tick = (osc_cnt == DIV_W'(INT_OSC_DIV_P - 1));

  // A rising edge on the frequency pin claims the conversion clock; silence releases it
  always_ff @(posedge mclk) begin
    if (rst) begin
      idle_cnt <= '0;
      ext_conv_clock <= 1'b0;
    end else if (f0_rise) begin
      idle_cnt <= '0;
      ext_conv_clock <= 1'b1;
    end else if (idle_cnt == IDLE_W'(EXT_CLK_TIMEOUT_P - 1)) begin
      ext_conv_clock <= 1'b0;
    end else begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end
  assign conv_tick = ext_conv_clock ? f0_rise : int_tick;

  // Clock pin strap, caught after the synchroniser has filled
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_cnt <= '0;
      ext_sck_mode <= 1'b0;
    end else if (strap_cnt != 2'(STRAP_WAIT)) begin
      strap_cnt <= strap_cnt + 1'b1;
      ext_sck_mode <= ~sck_s[1];
    end else if (cs_fall) begin
      ext_sck_mode <= ~sck_s[1];
    end
  end

  // Internal serial clock: idles low so the first edge seen by the host is a rise
  assign isck_run = (state == ST_DATA) && !ext_sck_mode && !cs_s[1];
  assign isck_toggle = isck_run && conv_tick && (isck_cnt == ISCK_W'(ISCK_HALF_TICKS - 1));
  always_ff @(posedge mclk) begin
    if (rst || !isck_run) begin
      isck_cnt <= '0;
      sck_out <= 1'b0;
    end else if (conv_tick) begin
      isck_cnt <= isck_toggle ? '0 : isck_cnt + 1'b1;
      if (isck_toggle) begin
        sck_out <= ~sck_out;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      sck_oe <= 1'b0;
    end else begin
      sck_oe <= isck_run;
    end
  end

  assign rise_ev = ext_sck_mode ? (sck_s[1] & ~sck_d) : (isck_toggle & ~sck_out);
  assign fall_ev = ext_sck_mode ? (~sck_s[1] & sck_d) : (isck_toggle & sck_out);

  assign conv_len = cfg_word[CFG_SPEED_POS] ? CONV_W'(CONV_TICKS_2X_P) : CONV_W'(CONV_TICKS_1X_P);
  assign push = (state == ST_STORE);
  assign pop = (state == ST_LOAD) && fifo_out_valid;
  assign next_word = build_word(sample_code, sample_over, sample_under);

  // Sequencer: convert, buffer the result, sleep, then the data phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_CONVERT;
      conv_cnt <= '0;
    end else begin
      unique case (state)
        ST_CONVERT: begin
          if (conv_tick) begin
            if (conv_cnt == conv_len - 1'b1) begin
              state <= ST_STORE;
            end else begin
              conv_cnt <= conv_cnt + 1'b1;
            end
          end
        end
        ST_STORE: begin
          // A full buffer holds the converter here rather than losing a result
          if (fifo_in_ready) begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (fifo_out_valid) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (cs_fall) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (cs_rise) begin
            conv_cnt <= '0;
            state <= (rise_cnt == '0) ? ST_SLEEP : ST_CONVERT;
          end else if (rise_ev && !cs_s[1] && rise_cnt == BITCNT_W'(WORD_BITS - 1)) begin
            conv_cnt <= '0;
            state <= ST_CONVERT;
          end
        end
        default: state <= ST_CONVERT;
      endcase
    end
  end

  // Bit counting and configuration capture on rising serial clock edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      rise_cnt <= '0;
      cfg_shift <= CFG_RESET;
    end else if (state != ST_DATA) begin
      rise_cnt <= '0;
    end else if (rise_ev && !cs_s[1]) begin
      rise_cnt <= rise_cnt + 1'b1;
      if (rise_cnt < BITCNT_W'(CFG_BITS)) begin
        cfg_shift <= {cfg_shift[CFG_BITS-2:0], sdi_s[1]};
      end
    end
  end

  // Configuration is adopted only once complete, as the next conversion starts
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_word <= CFG_RESET;
    end else if (state == ST_DATA && rise_cnt >= BITCNT_W'(CFG_BITS)) begin
      if (cs_rise || (rise_ev && !cs_s[1] && rise_cnt == BITCNT_W'(WORD_BITS - 1))) begin
        cfg_word <= cfg_shift;
      end
    end
  end

  // Output shift register; nothing but a load or a falling edge moves it
  always_ff @(posedge mclk) begin
    if (rst) begin
      shreg <= '0;
    end else if (pop) begin
      shreg <= fifo_out_data;
    end else if (state == ST_DATA && fall_ev && !cs_s[1] && rise_cnt != '0) begin
      shreg <= {shreg[WORD_BITS-2:0], 1'b0};
    end
  end

  // Serial data pin: status outside the data phase, released while deselected
  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_out <= 1'b1;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= ~cs_s[1];
      unique case (state)
        ST_SLEEP: serial_out <= 1'b0;
        ST_DATA: serial_out <= shreg[WORD_BITS-1];
        default: serial_out <= 1'b1;
      endcase
    end
  end

  // Calibration steps folded inside each conversion, invisible at the link
  always_ff @(posedge mclk) begin
    if (rst) begin
      cal_phase <= PH_IDLE;
    end else if (state != ST_CONVERT) begin
      cal_phase <= PH_IDLE;
    end else if (conv_cnt < (conv_len >> 2)) begin
      cal_phase <= PH_OFFSET_CAL;
    end else if (conv_cnt < (conv_len >> 1)) begin
      cal_phase <= PH_GAIN_CAL;
    end else begin
      cal_phase <= PH_SAMPLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_busy <= 1'b1;
      low_power <= 1'b0;
    end else begin
      conv_busy <= (state == ST_CONVERT) || (state == ST_STORE) || (state == ST_LOAD);
      low_power <= (state == ST_SLEEP) && cs_s[1];
    end
  end

  acs_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(next_word),
    .out_valid(fifo_out_valid),
    .out_ready(state == ST_LOAD),
    .out_data(fifo_out_data)
  );
endmodule : acs_control

// [test/acs_control_asserts.sv]
// Port-level timing checks for the converter control block.
// Bound into every acs_control instance; sees only its ports, single mclk domain.
module acs_control_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic [acs_pkg::CFG_BITS-1:0] cfg_word,
  input wire logic [1:0] cal_phase,
  input wire logic conv_busy,
  input wire logic low_power,
  input wire logic ext_sck_mode,
  input wire logic ext_conv_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_oe_released: assert property (cs_n [*6] |-> !serial_out_oe)
    else $error("serial_out_oe high with chip select high");
  a_cs_wakes: assert property ($fell(cs_n) |-> ##[3:6] serial_out_oe)
    else $error("serial_out_oe not raised after chip select fall");
  a_status_busy: assert property (serial_out_oe && conv_busy && $past(conv_busy, 2) |-> serial_out)
    else $error("status not high while converting");
  a_sleep_stays: assert property (low_power && cs_n |=> low_power && !conv_busy)
    else $error("sleep left with chip select high");
  a_ext_no_drive: assert property (ext_sck_mode |-> !sck_oe)
    else $error("clock driven in host clock mode");
  a_sck_release: assert property (cs_n [*6] |-> !sck_oe && !sck_out)
    else $error("clock driven with chip select high");
  a_cfg_hold: assert property (conv_busy && $past(conv_busy) && $past(conv_busy, 2) |-> $stable(cfg_word))
    else $error("configuration changed within a conversion");
  a_cal_idle: assert property (!conv_busy |-> cal_phase == 2'h0)
    else $error("calibration phase active outside conversion");
  c_offset_cal: cover property (cal_phase == 2'h1);
  c_gain_cal: cover property (cal_phase == 2'h2);
  c_dev_clock: cover property (sck_oe);
  c_ext_conv: cover property (ext_conv_clock);
endmodule : acs_control_asserts

bind acs_control acs_control_asserts u_chk (
  .mclk(mclk),
  .rst(rst),
  .cs_n(cs_n),
  .sck_out(sck_out),
  .sck_oe(sck_oe),
  .serial_out(serial_out),
  .serial_out_oe(serial_out_oe),
  .cfg_word(cfg_word),
  .cal_phase(cal_phase),
  .conv_busy(conv_busy),
  .low_power(low_power),
  .ext_sck_mode(ext_sck_mode),
  .ext_conv_clock(ext_conv_clock)
);

// [test/acs_host.sv]
// Host controller model: drives chip select, serial clock and configuration input.
// Assumes a pull-up on the clock pin, so a floated pin reads high.
module acs_host (
  input wire logic mclk,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic serial_out,
  output logic cs_n,
  output logic sck_pin,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Host clock half period held at the 125 ns minimum
  localparam int HALF = 25;
  logic host_drv = 1'b1;
  logic host_sck = 1'b0;
  logic tmo = 1'b0;
  initial cs_n = 1'b1;
  initial serial_in = 1'b0;
  assign sck_pin = sck_oe ? sck_out : (host_drv ? host_sck : 1'b1);
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic select(input logic lvl);
    tick(1);
    cs_n = lvl;
  endtask : select
  // Device clock may stall; give up after 100 cycles
  task automatic wait_pin(input logic lvl);
    for (int i = 0; i < 100 && sck_pin !== lvl; i++) tick(1);
    if (sck_pin !== lvl) tmo = 1'b1;
  endtask : wait_pin
  task automatic xfer(input int nbits, input logic [15:0] cfg, input logic dev_clk,
                      output logic [23:0] word);
    host_drv = ~dev_clk;
    host_sck = 1'b0;
    tick(10);
    cs_n = 1'b0;
    if (dev_clk) wait_pin(1'b0);
    for (int i = 0; i < nbits; i++) begin
      serial_in = (i < 16) ? cfg[15-i] : ~serial_in;
      if (dev_clk) wait_pin(1'b1);
      else begin
        tick(HALF);
        host_sck = 1'b1;
      end
      word[23-i] = serial_out;
      if (dev_clk && i < nbits - 1) wait_pin(1'b0);
      else if (!dev_clk) begin
        tick(HALF);
        host_sck = 1'b0;
      end
    end
    tick(HALF);
    cs_n = 1'b1;
    host_drv = 1'b1;
  endtask : xfer
endmodule : acs_host

// [test/acs_control_bench.sv]
// Self-checking bench for the converter control block with shortened counts.
// Assumes acs_host as the far side and the checker bound into the design.
module acs_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  localparam int C1 = 40;
  localparam int C2 = 20;
  localparam int D = 4;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic conv_clock_select = 1'b0;
  logic ext_on = 1'b0;
  logic [2:0] cc_cnt = 3'h0;
  logic [SAMPLE_BITS-1:0] sample_code = 18'h00123;
  logic sample_over = 1'b0;
  logic sample_under = 1'b0;
  logic cs_n, sck_pin, serial_in, sck_out, sck_oe, serial_out, serial_out_oe;
  logic conv_busy, low_power, ext_sck_mode, ext_conv_clock;
  logic [CFG_BITS-1:0] cfg_word;
  logic [1:0] cal_phase;
  int err_count = 0;
  int n_tests = 0;
  int busy_len = 0;
  int last_len = 0;
  acs_control #(.CONV_TICKS_1X_P(C1), .CONV_TICKS_2X_P(C2), .EXT_CLK_TIMEOUT_P(64),
    .INT_OSC_DIV_P(D)) DUT (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sck_in(sck_pin),
    .sck_out(sck_out), .sck_oe(sck_oe), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .conv_clock_select(conv_clock_select),
    .sample_code(sample_code), .sample_over(sample_over), .sample_under(sample_under),
    .cfg_word(cfg_word), .cal_phase(cal_phase), .conv_busy(conv_busy),
    .low_power(low_power), .ext_sck_mode(ext_sck_mode), .ext_conv_clock(ext_conv_clock));
  acs_host host (.mclk(mclk), .sck_out(sck_out), .sck_oe(sck_oe), .serial_out(serial_out),
    .cs_n(cs_n), .sck_pin(sck_pin), .serial_in(serial_in));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cc_cnt <= cc_cnt + 3'h1;
    if (ext_on && cc_cnt == 3'h7)
      conv_clock_select <= #1 ~conv_clock_select;
  end
  always @(posedge mclk) begin
    if (rst || conv_busy !== 1'b1) busy_len <= 0;
    else busy_len <= busy_len + 1;
    if (!rst && conv_busy === 1'b0 && busy_len != 0) last_len <= busy_len;
  end
  function automatic logic [23:0] wd(input logic s, input logic [RESULT_BITS-1:0] m);
    return {2'b00, s, m, TAIL_ZERO};
  endfunction : wd
  // Tick quantisation of the conversion clock makes the length slightly loose
  function automatic logic len_ok(input int exp);
    return last_len >= exp - 16 && last_len <= exp + 20;
  endfunction : len_ok
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic wait_sleep();
    for (int i = 0; i < 2000 && conv_busy !== 1'b0; i++) host.tick(1);
    if (conv_busy !== 1'b0) begin
      check("sleep reached", 24'h0, 24'(conv_busy));
      end_of_test();
    end
    host.tick(4);
  endtask : wait_sleep
  task automatic t_reset();
    host.tick(2);
    check("cfg_word", 24'h0, 24'(cfg_word));
    check("conv_busy", 24'h1, 24'(conv_busy));
    check("serial_out_oe", 24'h0, 24'(serial_out_oe));
    host.select(1'b0);
    host.tick(8);
    check("status busy", 24'h3, 24'({serial_out_oe, serial_out}));
    wait_sleep();
    check("1x length", 24'h1, 24'(len_ok(C1 * D)));
    check("status done", 24'h2, 24'({serial_out_oe, serial_out}));
    check("ext_sck_mode", 24'h1, 24'(ext_sck_mode));
    host.select(1'b1);
    host.tick(8);
    check("back to sleep", 24'h1, 24'({conv_busy, low_power}));
    $display("t_reset done");
  endtask : t_reset
  task automatic t_stream();
    logic [23:0] w;
    logic [15:0] cfg [4] = '{16'h5a80, 16'h0000, 16'h0000, 16'h0000};
    logic [19:0] nxt [4] = '{{2'b00, 18'h0abcd}, {2'b10, 18'h0}, {2'b01, 18'h0},
                             {2'b00, 18'h00123}};
    logic [23:0] exp_w [4] = '{wd(1'b1, 17'h00123), wd(1'b1, 17'h0abcd), wd(1'b1, MAG_MAX),
                               wd(1'b0, MAG_MIN)};
    for (int i = 0; i < 4; i++) begin
      sample_over = nxt[i][19];
      sample_under = nxt[i][18];
      sample_code = nxt[i][17:0];
      host.xfer(24, cfg[i], 1'b0, w);
      check("word", exp_w[i], w);
      check("busy after 24 bits", 24'h1, 24'(conv_busy));
      check("cfg_word", 24'(cfg[i]), 24'(cfg_word));
      wait_sleep();
      check("length", 24'h1, 24'(len_ok(cfg[i][CFG_SPEED_POS] ? C2 * D : C1 * D)));
    end
    $display("t_stream done");
  endtask : t_stream
  task automatic t_abort();
    logic [23:0] w;
    host.select(1'b0);
    host.tick(10);
    host.select(1'b1);
    host.tick(8);
    check("short select", 24'h1, 24'({conv_busy, low_power}));
    // Leading ones in the cut configuration would show if it were wrongly adopted
    host.xfer(5, 16'hf880, 1'b0, w);
    check("kept word", 24'(5'b00100), 24'(w[23:19]));
    host.tick(8);
    check("abort converts", 24'h1, 24'(conv_busy));
    check("cal offset", 24'(PH_OFFSET_CAL), 24'(cal_phase));
    check("cfg kept", 24'h0, 24'(cfg_word));
    wait_sleep();
    $display("t_abort done");
  endtask : t_abort
  task automatic t_int_sck();
    logic [23:0] w;
    host.xfer(24, 16'h0000, 1'b1, w);
    check("device clock word", wd(1'b1, 17'h00123), w);
    check("ext_sck_mode", 24'h0, 24'(ext_sck_mode));
    check("clock timeout", 24'h0, 24'(host.tmo));
    wait_sleep();
    $display("t_int_sck done");
  endtask : t_int_sck
  task automatic t_ext_conv();
    logic [23:0] w;
    ext_on = 1'b1;
    host.tick(60);
    check("ext_conv_clock on", 24'h1, 24'(ext_conv_clock));
    host.xfer(24, 16'h0000, 1'b0, w);
    check("ext clock word", wd(1'b1, 17'h00123), w);
    wait_sleep();
    check("ext length", 24'h1, 24'(len_ok(C1 * 16)));
    ext_on = 1'b0;
    host.tick(100);
    check("ext_conv_clock off", 24'h0, 24'(ext_conv_clock));
    $display("t_ext_conv done");
  endtask : t_ext_conv
  initial begin
    repeat (20) @(posedge mclk);
    #1 rst = 1'b0;
    t_reset();
    t_stream();
    t_abort();
    t_int_sck();
    t_ext_conv();
    end_of_test();
  end
endmodule : acs_control_bench
